//--- sded_decoder.sv
`timescale 1ns/100ps
module sded_decoder (
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  input  wire logic                          scan_start,
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire logic [7:0]                    in_byte,
  input  wire logic                          fetch_req,
  input  wire logic [4:0]                    fetch_len,
  output logic                               fetch_ready,
  output logic                               fetch_done,
  output logic [15:0]                        fetch_data,
  input  wire logic                          resync_expect,
  output logic                               restart_seen,
  output logic                               stat_reset,
  output logic                               scan_end,
  output logic [7:0]                         marker_code,
  output logic [15:0]                        line_count,
  output logic                               decode_error,
  input  wire logic                          blk_start,
  input  wire logic [1:0]                    comp_sel,
  input  wire logic [sded_pkg::TBL_W-1:0]    dc_table,
  input  wire logic [sded_pkg::TBL_W-1:0]    ac_table,
  output logic                               blk_ready,
  output logic                               dec_req,
  output logic                               dec_is_ac,
  output logic [sded_pkg::TBL_W-1:0]         dec_table,
  output sded_pkg::sded_kind_t               dec_kind,
  output logic [5:0]                         dec_pos,
  output logic [3:0]                         dec_step,
  input  wire logic                          dec_ack,
  input  wire logic                          dec_bit,
  output logic                               coef_valid,
  input  wire logic                          coef_ready,
  output logic [5:0]                         coef_index,
  output logic [sded_pkg::COEF_W-1:0]        coef_value
);
  import sded_pkg::*;

  // ******************************************************
  // Byte fetcher and single-bit reader
  // ******************************************************
  typedef enum {RB_DATA, RB_FF, RB_DNL, RB_HALT} sded_rb_t;

  sded_rb_t    rb_r;
  logic [7:0]  byte_r;
  logic [3:0]  bits_left_counter_r;
  logic [2:0]  exp_num_r;
  logic        resync_pend_r;
  logic [1:0]  dnl_cnt_r;
  logic        fetch_busy_r;
  logic [4:0]  fetch_cnt_r;
  logic [15:0] shift_r;
  logic        take;
  logic        need_byte;
  logic        bit_avail;
  logic        bit_val;
  logic        is_rst;
  logic        restart_ev;
  logic        rst_bad;

  function automatic logic marker_is_rst(input logic [7:0] b);
    return (b >= MARK_RST0) && (b <= MARK_RST7);
  endfunction

  assign need_byte   = (bits_left_counter_r == 4'h0) && (fetch_busy_r || resync_pend_r);
  assign in_ready    = (rb_r == RB_DATA) ? need_byte : (rb_r == RB_FF || rb_r == RB_DNL);
  assign take        = in_valid && in_ready;
  assign is_rst      = marker_is_rst(in_byte);
  assign restart_ev  = take && (rb_r == RB_FF) && is_rst;
  // RULE_02 halted reader feeds zero bits so a pending fetch still finishes
  assign bit_avail   = (bits_left_counter_r != 4'h0) || (rb_r == RB_HALT);
  assign bit_val     = (rb_r == RB_HALT) ? 1'b0 : byte_r[bits_left_counter_r[2:0] - 3'h1];
  assign fetch_ready = !fetch_busy_r;
  // RULE_20 RULE_21
  assign rst_bad     = restart_ev && (in_byte[2:0] != exp_num_r);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rb_r                <= RB_DATA;
      byte_r              <= BYTE_STUFF;
      bits_left_counter_r <= 4'h0;
      dnl_cnt_r           <= 2'h0;
      marker_code         <= BYTE_STUFF;
      line_count          <= 16'h0000;
    end else if (scan_start) begin
      rb_r                <= RB_DATA;
      bits_left_counter_r <= 4'h0; // RULE_03
      dnl_cnt_r           <= 2'h0;
    end else begin
      if (fetch_busy_r && (fetch_cnt_r != 5'h0) && bits_left_counter_r != 4'h0) begin
        bits_left_counter_r <= bits_left_counter_r - 4'h1; // RULE_02
      end
      if (take) begin
        case (rb_r)
          RB_DATA: begin
            if (in_byte == BYTE_MARK) begin
              rb_r <= RB_FF;
            end else begin
              byte_r              <= in_byte;
              bits_left_counter_r <= BITS_PER_BYTE; // RULE_04
            end
          end
          RB_FF: begin
            if (in_byte == BYTE_STUFF) begin
              byte_r              <= BYTE_MARK; // RULE_23
              bits_left_counter_r <= BITS_PER_BYTE; // RULE_04
              rb_r                <= RB_DATA;
            end else if (in_byte == BYTE_MARK) begin
              rb_r <= RB_FF;
            end else if (is_rst) begin
              // Leftover bits of the old interval are padding
              bits_left_counter_r <= 4'h0; // RULE_03 RULE_24
              rb_r                <= RB_DATA;
            end else if (in_byte == MARK_DNL) begin
              marker_code <= in_byte; // RULE_05
              dnl_cnt_r   <= 2'h0;
              rb_r        <= RB_DNL;
            end else begin
              marker_code <= in_byte; // RULE_02 RULE_05 RULE_23
              rb_r        <= RB_HALT;
            end
          end
          RB_DNL: begin
            // Two length bytes, then the line count high and low
            if (dnl_cnt_r[1]) begin
              line_count <= {line_count[7:0], in_byte}; // RULE_06
            end
            dnl_cnt_r <= dnl_cnt_r + 2'h1;
            if (dnl_cnt_r == DNL_LEN_BYTES) begin
              rb_r <= RB_HALT; // RULE_06
            end
          end
          default: begin
            rb_r <= rb_r;
          end
        endcase
      end
    end
  end

  // Restart bookkeeping and error reporting
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      exp_num_r     <= 3'h0;
      resync_pend_r <= 1'b0;
      restart_seen  <= 1'b0;
      stat_reset    <= 1'b0;
      scan_end      <= 1'b0;
      decode_error  <= 1'b0;
    end else begin
      restart_seen <= restart_ev;
      stat_reset   <= scan_start || restart_ev; // RULE_08
      scan_end     <= take && ((rb_r == RB_FF && !is_rst && in_byte != BYTE_STUFF
                      && in_byte != BYTE_MARK && in_byte != MARK_DNL)
                      || (rb_r == RB_DNL && dnl_cnt_r == DNL_LEN_BYTES)); // RULE_06
      // Data byte where a marker was due means the expected marker is missing
      decode_error <= rst_bad || (resync_pend_r && take && rb_r == RB_DATA
                      && in_byte != BYTE_MARK) || mag_err; // RULE_21
      if (scan_start) begin
        exp_num_r     <= 3'h0;
        resync_pend_r <= 1'b0;
      end else begin
        if (restart_ev) begin
          exp_num_r <= in_byte[2:0] + 3'h1; // RULE_20 RULE_24
        end
        if (resync_expect) begin
          resync_pend_r <= 1'b1;
        end else if (restart_ev || (resync_pend_r && take && rb_r == RB_DATA
                     && in_byte != BYTE_MARK)) begin
          resync_pend_r <= 1'b0;
        end
      end
    end
  end

  // ******************************************************
  // Bit-field fetch
  // ******************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fetch_busy_r <= 1'b0;
      fetch_cnt_r  <= 5'h0;
      shift_r      <= 16'h0000;
      fetch_done   <= 1'b0;
      fetch_data   <= 16'h0000;
    end else begin
      fetch_done <= 1'b0;
      if (!fetch_busy_r) begin
        if (fetch_req) begin
          fetch_busy_r <= 1'b1;
          fetch_cnt_r  <= fetch_len;
          shift_r      <= 16'h0000;
        end
      end else if (fetch_cnt_r == 5'h0) begin
        fetch_busy_r <= 1'b0;
        fetch_done   <= 1'b1;
        fetch_data   <= shift_r;
      end else if (bit_avail && !scan_start) begin
        shift_r     <= {shift_r[14:0], bit_val}; // RULE_01
        fetch_cnt_r <= fetch_cnt_r - 5'h1;
      end
    end
  end

  // ******************************************************
  // Arithmetic coefficient decoder
  // ******************************************************
  typedef enum {CD_IDLE, CD_DECIDE, CD_EMIT, CD_FILL} sded_cd_t;

  sded_cd_t             cd_r;
  sded_kind_t           kind_r;
  logic                 is_ac_r;
  logic [5:0]           k_r;
  logic                 neg_r;
  logic [15:0]          bound_r;
  logic [15:0]          mag_r;
  logic [3:0]           step_r;
  logic [TBL_W-1:0]     dct_r;
  logic [TBL_W-1:0]     act_r;
  logic [1:0]           comp_r;
  logic [COEF_W-1:0]    pred_r [NUM_COMP];
  logic [COEF_W-1:0]    emit_val_r;
  logic [5:0]           emit_idx_r;
  logic                 buf_ready;
  logic                 got;
  logic                 mag_err;
  logic [15:0]          half;
  logic [COEF_W-1:0]    value;

  assign got       = (cd_r == CD_DECIDE) && dec_ack;
  assign half      = {1'b0, bound_r[15:1]};
  assign dec_req   = (cd_r == CD_DECIDE);
  assign dec_kind  = kind_r;
  assign dec_is_ac = is_ac_r;
  assign dec_table = is_ac_r ? act_r : dct_r; // RULE_07 RULE_09 RULE_15
  assign dec_pos   = k_r;
  assign dec_step  = step_r;
  assign blk_ready = (cd_r == CD_IDLE);
  assign mag_err   = got && (kind_r == DK_CATEGORY) && dec_bit && bound_r == BOUND_TOP; // RULE_21
  // RULE_16 RULE_17
  assign value     = neg_r ? (16'h0000 - (mag_r + 16'h0001)) : (mag_r + 16'h0001);

  always_ff @(posedge sys_clk) begin
    if (!reset_n || scan_start || restart_ev) begin
      for (int i = 0; i < NUM_COMP; i++) begin
        pred_r[i] <= 16'h0000; // RULE_22
      end
    end else if (cd_r == CD_EMIT && buf_ready && !is_ac_r) begin
      pred_r[comp_r] <= emit_val_r; // RULE_22
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cd_r       <= CD_IDLE;
      kind_r     <= DK_DC_ZERO;
      is_ac_r    <= 1'b0;
      k_r        <= ZZ_DC;
      neg_r      <= 1'b0;
      bound_r    <= 16'h0001;
      mag_r      <= 16'h0000;
      step_r     <= 4'h0;
      dct_r      <= '0;
      act_r      <= '0;
      comp_r     <= 2'h0;
      emit_val_r <= 16'h0000;
      emit_idx_r <= ZZ_DC;
    end else if (scan_start) begin
      cd_r <= CD_IDLE;
    end else begin
      case (cd_r)
        CD_IDLE: begin
          if (blk_start) begin
            dct_r   <= dc_table;
            act_r   <= ac_table;
            comp_r  <= comp_sel;
            is_ac_r <= 1'b0;
            k_r     <= ZZ_DC;
            kind_r  <= DK_DC_ZERO; // RULE_10
            cd_r    <= CD_DECIDE;
          end
        end
        CD_DECIDE: begin
          if (mag_err) begin
            cd_r <= CD_IDLE; // RULE_21
          end else if (got) begin
            case (kind_r)
              DK_DC_ZERO: begin
                if (dec_bit) begin
                  kind_r <= DK_SIGN; // RULE_10
                end else begin
                  emit_val_r <= pred_r[comp_r]; // RULE_22
                  emit_idx_r <= ZZ_DC;
                  cd_r       <= CD_EMIT;
                end
              end
              DK_SIGN: begin
                neg_r   <= dec_bit; // RULE_17
                bound_r <= 16'h0001;
                mag_r   <= 16'h0000;
                step_r  <= 4'h0;
                kind_r  <= DK_CATEGORY; // RULE_16
              end
              DK_CATEGORY: begin
                step_r <= step_r + 4'h1;
                if (dec_bit) begin
                  bound_r <= {bound_r[14:0], 1'b0}; // RULE_18
                end else begin
                  bound_r <= half; // RULE_18
                  mag_r   <= half;
                  step_r  <= 4'h0;
                  if (half > 16'h0001) begin
                    kind_r <= DK_LOW_BIT; // RULE_19
                  end else begin
                    cd_r <= CD_EMIT;
                  end
                end
              end
              DK_LOW_BIT: begin
                if (dec_bit) begin
                  mag_r <= mag_r | half; // RULE_19
                end
                bound_r <= half;
                step_r  <= step_r + 4'h1;
                if (half == 16'h0001) begin
                  cd_r <= CD_EMIT;
                end
              end
              DK_BLOCK_END: begin
                if (dec_bit) begin
                  emit_val_r <= 16'h0000;
                  emit_idx_r <= k_r;
                  cd_r       <= CD_FILL; // RULE_12
                end else begin
                  kind_r <= DK_ZERO_RUN; // RULE_13
                end
              end
              default: begin
                if (dec_bit) begin
                  kind_r <= DK_SIGN; // RULE_13
                end else begin
                  emit_val_r <= 16'h0000;
                  emit_idx_r <= k_r;
                  cd_r       <= CD_EMIT; // RULE_13
                end
              end
            endcase
          end
          if (got && ((kind_r == DK_CATEGORY && !dec_bit && half <= 16'h0001)
              || (kind_r == DK_LOW_BIT && half == 16'h0001))) begin
            // Final magnitude ready: value or DC sum goes out next
            emit_idx_r <= k_r;
            emit_val_r <= is_ac_r ? value : pred_r[comp_r] + value; // RULE_15 RULE_22
            if (kind_r == DK_CATEGORY) begin
              emit_val_r <= (neg_r ? (16'h0000 - (half + 16'h0001)) : (half + 16'h0001))
                          + (is_ac_r ? 16'h0000 : pred_r[comp_r]);
            end else if (dec_bit) begin
              emit_val_r <= neg_r ? (16'h0000 - ((mag_r | half) + 16'h0001))
                          + (is_ac_r ? 16'h0000 : pred_r[comp_r])
                          : ((mag_r | half) + 16'h0001)
                          + (is_ac_r ? 16'h0000 : pred_r[comp_r]);
            end
          end
        end
        CD_EMIT: begin
          if (buf_ready) begin
            is_ac_r <= 1'b1;
            if (!is_ac_r) begin
              k_r    <= ZZ_FIRST_AC; // RULE_11
              kind_r <= DK_BLOCK_END; // RULE_12
              cd_r   <= CD_DECIDE;
            end else if (k_r == BAND_END) begin
              cd_r <= CD_IDLE; // RULE_11 RULE_14
            end else begin
              k_r    <= k_r + 6'h01; // RULE_11 RULE_13
              kind_r <= (kind_r == DK_ZERO_RUN) ? DK_ZERO_RUN : DK_BLOCK_END; // RULE_14
              cd_r   <= CD_DECIDE;
            end
          end
        end
        CD_FILL: begin
          if (buf_ready) begin
            emit_idx_r <= emit_idx_r + 6'h01;
            if (emit_idx_r == BAND_END) begin
              cd_r <= CD_IDLE; // RULE_12
            end
          end
        end
        default: begin
          cd_r <= CD_IDLE;
        end
      endcase
    end
  end

  // ******************************************************
  // Output buffer
  // ******************************************************
  sded_buf2 #(
    .WIDTH (COEF_W + 6)
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (cd_r == CD_EMIT || cd_r == CD_FILL),
    .in_ready  (buf_ready),
    .in_data   ({emit_idx_r, emit_val_r}),
    .out_valid (coef_valid),
    .out_ready (coef_ready),
    .out_data  ({coef_index, coef_value})
  );
endmodule

//--- sded_pkg.sv
// Behaviour
// RULE_01: Bit-field fetch shifts requested bits into result LSBs, most significant first.
// RULE_02: Bits leave each byte MSB first; stuff bytes dropped; markers flagged, not passed.
// RULE_03: Remaining-bit count cleared at scan start and after each restart marker.
// RULE_04: Input fetched one byte at a time; each fetch loads the count with 8.
// RULE_05: Only restart markers inside data; at scan end line-count marker expected.
// RULE_06: Line-count marker loads current line count and ends the scan.
// RULE_07: Up to four DC and four AC code tables selectable per scan.
// RULE_08: Probability estimates reset at every scan start and restart interval.
// RULE_09: Four DC and four AC conditioning tables with statistics usable per scan.
// RULE_10: DC: zero decision first; sign and magnitude only when non-zero.
// RULE_11: AC coefficients decoded in zig-zag order from index 1 to 63.
// RULE_12: End-of-block decision at loop top; one zeroes remaining coefficients.
// RULE_13: Zero-run decisions advance the index; non-zero decodes sign and magnitude.
// RULE_14: After a non-zero AC value, decode end-of-block unless index at band end.
// RULE_15: Values are signed 16-bit; same tree for DC and AC, separate statistics.
// RULE_16: Sign, then category, then low bits; magnitude field plus one is magnitude.
// RULE_17: Polarity decision 0 gives positive, 1 gives negative.
// RULE_18: Bound shifts left per one decision until zero, then right by one.
// RULE_19: Low magnitude bits decoded one decision each, most significant first.
// RULE_20: Expected restart number modulo 8 compared with the marker's low bits.
// RULE_21: Flag error on missing expected restart marker or out-of-range magnitude.
// RULE_22: DC prediction zeroed per scan and restart; DC equals prediction plus delta.
// RULE_23: 0xFF then 0x00 is data 0xFF; any other follower is a marker.
// RULE_24: After restart, advance expected number modulo eight and refetch at byte boundary.
package sded_pkg;
  localparam int          COEF_W       = 16;
  localparam int          TBL_W        = 2;
  localparam int          NUM_COMP     = 4;
  localparam logic [7:0]  BYTE_MARK    = 8'hFF;
  localparam logic [7:0]  BYTE_STUFF   = 8'h00;
  localparam logic [7:0]  MARK_RST0    = 8'hD0;
  localparam logic [7:0]  MARK_RST7    = 8'hD7;
  localparam logic [7:0]  MARK_DNL     = 8'hDC;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [1:0]  DNL_LEN_BYTES = 2'h3;
  localparam logic [5:0]  ZZ_DC        = 6'h00;
  localparam logic [5:0]  ZZ_FIRST_AC  = 6'h01;
  localparam logic [5:0]  BAND_END     = 6'h3F;
  localparam logic [15:0] BOUND_TOP    = 16'h8000;

  // Kind of binary decision asked of the arithmetic core
  typedef enum logic [2:0] {
    DK_DC_ZERO,
    DK_SIGN,
    DK_CATEGORY,
    DK_LOW_BIT,
    DK_BLOCK_END,
    DK_ZERO_RUN
  } sded_kind_t;
endpackage

//--- sded_buf2.sv
`timescale 1ns/100ps
module sded_buf2 #(
  parameter int WIDTH = 22
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wr_ptr_r;
  logic             rd_ptr_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- sded_monitor.sv
`timescale 1ns/100ps
module sded_monitor (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 scan_start,
  input wire logic                 fetch_req,
  input wire logic [4:0]           fetch_len,
  input wire logic                 fetch_ready,
  input wire logic                 fetch_done,
  input wire logic                 restart_seen,
  input wire logic                 stat_reset,
  input wire logic                 blk_start,
  input wire logic                 blk_ready,
  input wire logic                 dec_req,
  input wire logic                 dec_ack,
  input wire logic                 dec_bit,
  input wire sded_pkg::sded_kind_t dec_kind,
  input wire logic [5:0]           dec_pos,
  input wire logic                 coef_valid,
  input wire logic                 coef_ready,
  input wire logic [5:0]           coef_index,
  input wire logic [15:0]          coef_value
);
  import sded_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire take = dec_req && dec_ack;
  // ****
  // Checks
  // ****
  a_fetch_early: assert property (fetch_req && fetch_ready && fetch_len != 5'h00
    |=> !fetch_done) else $error("fetch answered too early");
  a_scan_stat: assert property (scan_start |-> ##[1:2] stat_reset)
    else $error("no statistics reset after scan start");
  a_restart_stat: assert property (restart_seen |-> ##[0:2] stat_reset)
    else $error("no statistics reset after restart");
  a_dc_first: assert property (blk_start && blk_ready
    |=> dec_req && dec_kind == DK_DC_ZERO) else $error("block did not open with zero decision");
  a_dc_zero_skip: assert property (take && dec_kind == DK_DC_ZERO && !dec_bit
    |=> !(dec_req && dec_kind == DK_SIGN)) else $error("sign decoded for zero delta");
  a_sign_then_cat: assert property (take && dec_kind == DK_SIGN
    |=> dec_req && dec_kind == DK_CATEGORY) else $error("category did not follow sign");
  a_eob_pos: assert property (dec_req && dec_kind == DK_BLOCK_END
    |-> dec_pos >= ZZ_FIRST_AC) else $error("block end decision at wrong index");
  a_eob_fill: assert property (take && dec_kind == DK_BLOCK_END && dec_bit
    |=> !dec_req [*8]) else $error("decisions continued after block end");
  a_dec_hold: assert property (dec_req && !dec_ack
    |=> dec_req && $stable(dec_kind) && $stable(dec_pos)) else $error("decision context changed");
  a_coef_hold: assert property (coef_valid && !coef_ready
    |=> coef_valid && $stable(coef_value) && $stable(coef_index)) else $error("coefficient changed");
  c_restart: cover property (restart_seen);
  c_last_coef: cover property (coef_valid && coef_ready && coef_index == BAND_END);
  c_low_bit: cover property (take && dec_kind == DK_LOW_BIT);
endmodule

//--- sded_byte_src.sv
`timescale 1ns/100ps
module sded_byte_src (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       slow,
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic      [7:0] in_byte
);
  logic [7:0] q [$];
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      in_valid <= 1'b0;
      in_byte  <= 8'h5A;
    end else if (!in_valid || in_ready) begin
      // Idle byte flips each cycle so a late sample never sees stale data
      if (q.size() != 0 && !(slow && in_valid)) begin
        in_valid <= 1'b1;
        in_byte  <= q.pop_front();
      end else begin
        in_valid <= 1'b0;
        in_byte  <= ~in_byte;
      end
    end
  end
endmodule

//--- sded_tb.sv
`timescale 1ns/100ps
module tb;
  import sded_pkg::*;
  logic             sys_clk = 1'b0, reset_n = 1'b0, scan_start = 1'b0, fetch_req = 1'b0;
  logic             resync_expect = 1'b0, blk_start = 1'b0, dec_ack = 1'b0, dec_bit = 1'b0;
  logic             coef_ready = 1'b0, slow = 1'b0;
  logic [4:0]       fetch_len = 5'h00;
  logic [1:0]       comp_sel = 2'h0;
  logic [TBL_W-1:0] dc_table = 2'h0, ac_table = 2'h0, dec_table;
  logic             in_valid, in_ready, fetch_ready, fetch_done, restart_seen, stat_reset;
  logic             scan_end, decode_error, blk_ready, dec_req, dec_is_ac, coef_valid;
  logic [7:0]       in_byte, marker_code;
  logic [15:0]      fetch_data, line_count, coef_value;
  sded_kind_t       dec_kind;
  logic [5:0]       dec_pos, coef_index;
  logic [3:0]       dec_step, seen;
  logic [15:0]      got [64];
  logic             dq [$];
  int               fail_count = 0, samples_checked = 0, cyc = 0, ncoef = 0;
  logic [20:0]      rows [6] = '{{5'h00, 16'h0000}, {5'h04, 16'h000A}, {5'h04, 16'h0005},
                                 {5'h0C, 16'h0FF3}, {5'h04, 16'h000C}, {5'h10, 16'h1234}};
  logic [8:0]       mks [3] = '{{8'hD0, 1'b0}, {8'hD5, 1'b1}, {8'hD6, 1'b0}};
  sded_decoder u_dut (.*);
  sded_byte_src u_src (.*);
  always #5 sys_clk = ~sys_clk;
  // ****
  // Tasks
  // ****
  task automatic check(input string nm, input logic [15:0] seen_v, input logic [15:0] exp);
    samples_checked++;
    if (seen_v !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic send(input logic [47:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) u_src.push(v[i*8+:8]);
  endtask
  task automatic watch(input int n);
    seen = 4'h0;
    repeat (n) begin
      @(negedge sys_clk);
      seen = seen | {restart_seen, scan_end, decode_error, stat_reset};
    end
  endtask
  task automatic pulse(input bit rs);
    @(posedge sys_clk);
    if (rs) resync_expect <= 1'b1;
    else scan_start <= 1'b1;
    @(posedge sys_clk);
    resync_expect <= 1'b0;
    scan_start <= 1'b0;
  endtask
  task automatic fetch(input logic [4:0] n, input logic [15:0] exp, input bit chk);
    int k = 0;
    @(posedge sys_clk);
    fetch_req <= 1'b1;
    fetch_len <= n;
    do begin
      @(negedge sys_clk);
      k++;
    end while (fetch_ready !== 1'b1 && k < 200);
    @(posedge sys_clk);
    fetch_req <= 1'b0;
    if (chk) begin
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (fetch_done !== 1'b1 && k < 200);
      check("fetch_done", fetch_done, 1'b1);
      check("fetch_data", fetch_data, exp);
    end
  endtask
  task automatic run_blk(input logic [1:0] c, input logic [11:0] b, input int n,
                         input logic [15:0] dc, input logic [15:0] ac2);
    int k;
    @(negedge sys_clk);
    for (k = n - 1; k >= 0; k--) dq.push_back(b[k]);
    ncoef = 0;
    @(posedge sys_clk);
    blk_start <= 1'b1;
    comp_sel  <= c;
    dc_table  <= c;
    ac_table  <= ~c;
    @(posedge sys_clk);
    blk_start <= 1'b0;
    k = 0;
    while (ncoef < 64 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    for (k = 0; k < 64; k++)
      check("coef_value", got[k], (k == 0) ? dc : ((k == 2) ? ac2 : 16'h0000));
    check("decisions_left", 16'(dq.size()), 16'h0000);
  endtask
  // ****
  // Decision responder, coefficient sink, timeout
  // ****
  // Ack only every other pair of cycles so the decoder must hold its context
  always @(posedge sys_clk) begin
    if (dec_req && dec_ack) void'(dq.pop_front());
    if (dec_req && dec_ack) check("dec_table", dec_table, dec_is_ac ? ac_table : dc_table);
    dec_ack <= dq.size() != 0 && cyc[1];
    dec_bit <= (dq.size() != 0) ? dq[0] : 1'b0;
  end
  always @(posedge sys_clk) begin
    if (coef_valid && coef_ready) begin
      check("coef_index", 16'(coef_index), 16'(ncoef));
      got[coef_index] = coef_value;
      ncoef++;
    end
  end
  // Stalls of four cycles fill the two-entry buffer until it refuses
  always @(posedge sys_clk) begin
    cyc++;
    coef_ready <= cyc[3:2] != 2'h0;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (7) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset_outs", {fetch_ready, blk_ready, coef_valid, in_ready}, 16'h000C);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    pulse(1'b0);
    watch(4);
    check("stat_reset", seen[0], 1'b1);
    send(48'hA5FF003C1234, 6);
    for (int i = 0; i < 6; i++) fetch(rows[i][20:16], rows[i][15:0], 1'b1);
    $display("test fetch done");
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      send({32'h0, BYTE_MARK, mks[i][8:1]}, 2);
      pulse(1'b1);
      watch(20);
      check("restart_seen", seen[3], 1'b1);
      check("decode_error", seen[1], mks[i][0]);
      check("stat_reset", seen[0], 1'b1);
    end
    send(48'h81, 1);
    fetch(5'h01, 16'h0001, 1'b1);
    $display("test restart done");
    run_blk(2'h1, 12'hF49, 12, 16'hFFFC, 16'h0001);
    run_blk(2'h1, 12'h001, 2, 16'hFFFC, 16'h0000);
    run_blk(2'h2, 12'h001, 2, 16'h0000, 16'h0000);
    pulse(1'b0);
    watch(4);
    run_blk(2'h1, 12'h001, 2, 16'h0000, 16'h0000);
    $display("test block done");
    send(48'hFFDC0004012C, 6);
    fetch(5'h01, 16'h0000, 1'b0);
    watch(40);
    check("scan_end", seen[2], 1'b1);
    check("line_count", line_count, 16'h012C);
    check("marker_code", marker_code, 16'h00DC);
    $display("test marker done");
    end_sim();
  end
endmodule
bind sded_decoder sded_monitor u_mon (.*);
